/* File: core/lsft_pkg.sv */
// Package for the panel scan and frame timing block.
// Assumes one 50 MHz clock; all offsets and counts are used as lsft_pkg::name.
package lsft_pkg;
  localparam int GATE_LINES = 320;
  localparam logic [8:0] LINE_FIRST = 9'h0_001;
  localparam logic [8:0] LINE_LAST = 9'h0_140;
  localparam logic [8:0] LINE_LAST_ODD = 9'h0_13F;
  localparam logic [8:0] LINE_FIRST_EVEN = 9'h0_002;
  // Register word addresses
  localparam logic [3:0] ADDR_SCAN = 4'h0;
  localparam logic [3:0] ADDR_TIMING = 4'h1;
  localparam logic [3:0] ADDR_PORCH = 4'h2;
  localparam logic [3:0] ADDR_GAMMA_POS = 4'h3;
  localparam logic [3:0] ADDR_GAMMA_NEG = 4'h4;
  localparam logic [3:0] ADDR_PARTIAL = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_TAP = 4'h7;
  // Field positions in the scan control word
  localparam int BIT_INTERLEAVE = 0;
  localparam int BIT_REVERSE = 1;
  localparam int BIT_EIGHT_COLOUR = 2;
  localparam int BIT_FRAME_INV = 3;
  localparam int BIT_PARTIAL = 4;
  localparam int BIT_ENABLE = 5;
  // Reset values
  localparam logic [5:0] RST_SCAN = 6'h00;
  localparam logic [4:0] RST_CLOCKS_PER_LINE = 5'h10;
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic [8:0] RST_DRIVEN_LINES = 9'h140;
  localparam logic [3:0] RST_FRONT_PORCH = 4'h2;
  localparam logic [3:0] RST_BACK_PORCH = 4'hE;
  localparam logic [31:0] RST_GAMMA = 32'h0000_0000;
  localparam logic [31:0] RST_PARTIAL = 32'h0000_0000;
  // Register read wait states
  localparam int READ_WAIT_CYCLES = 1;
  typedef enum {LSFT_IDLE, LSFT_DRAW, LSFT_BLANK} lsft_state_e;
endpackage : lsft_pkg

/* File: core/lsft_line_order.sv */
// Gate line order generator: first line and successor in the chosen scan order.
// Assumes the caller holds the mode bits stable within a frame.
module lsft_line_order (
  input wire logic i_interleave,
  input wire logic i_reverse,
  input wire logic [8:0] i_line,
  output logic [8:0] o_first,
  output logic [8:0] o_next,
  output logic o_last
);
  always_comb
  begin
    o_first = lsft_pkg::LINE_FIRST;
    o_next = i_line;
    o_last = 1'b0;
    case ({i_interleave, i_reverse})
      2'b00:
      begin
        o_first = lsft_pkg::LINE_FIRST;
        o_next = i_line + 9'h001;
        o_last = (i_line == lsft_pkg::LINE_LAST);
      end
      2'b01:
      begin
        o_first = lsft_pkg::LINE_LAST;
        o_next = i_line - 9'h001;
        o_last = (i_line == lsft_pkg::LINE_FIRST);
      end
      2'b10:
      begin
        o_first = lsft_pkg::LINE_FIRST;
        // Odd lines ascending then even lines ascending
        o_next = (i_line == lsft_pkg::LINE_LAST_ODD) ? lsft_pkg::LINE_FIRST_EVEN : i_line + 9'h002;
        o_last = (i_line == lsft_pkg::LINE_LAST);
      end
      default:
      begin
        o_first = lsft_pkg::LINE_LAST;
        // Even lines descending then odd lines descending
        o_next = (i_line == lsft_pkg::LINE_FIRST_EVEN) ? lsft_pkg::LINE_LAST_ODD : i_line - 9'h002;
        o_last = (i_line == lsft_pkg::LINE_FIRST);
      end
    endcase
  end
endmodule : lsft_line_order

/* File: core/lsft_scan_timing.sv */
// Frame timing, gate scan, polarity and gamma selection for the panel drive.
// Assumes an Avalon-MM master on i_clk; i_clk stands for the oscillator clock.
////////////////////////////////////////////////////////////////////////////////
module lsft_scan_timing (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [17:0] i_dot,
  output logic [8:0] o_gate_line,
  output logic o_gate_active,
  output logic o_line_start,
  output logic o_frame_start,
  output logic o_polarity,
  output logic o_non_lit,
  output logic [17:0] o_source_dot,
  output logic o_mid_levels_on,
  output logic [4:0] o_level0_amp,
  output logic [4:0] o_level31_amp,
  output logic [2:0] o_grad_level4,
  output logic [2:0] o_grad_level27,
  output logic [17:0] o_fine_levels,
  output logic [1:0] o_tap_low,
  output logic [1:0] o_tap_high,
  output logic [1:0] o_ratio_low,
  output logic [1:0] o_ratio_high
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [5:0] scan;
    logic [4:0] clocks_per_line;
    logic [1:0] div;
    logic [8:0] driven_line_count;
    logic [3:0] front_porch_lines;
    logic [3:0] back_porch_lines;
    logic [31:0] gamma_pos;
    logic [31:0] gamma_neg;
    logic [31:0] partial;
    logic [31:0] tap;
    lsft_pkg::lsft_state_e state;
    logic [8:0] line;
    logic [8:0] line_index;
    logic [7:0] clk_count;
    logic [4:0] blank_count;
    logic polarity;
    logic line_start;
    logic frame_start;
    logic [17:0] source_dot;
    logic read_pending;
    logic [31:0] readdata;
    logic [4:0] level0_amp;
    logic [4:0] level31_amp;
    logic [2:0] grad_level4;
    logic [2:0] grad_level27;
    logic [17:0] fine_levels;
    logic [1:0] tap_low;
    logic [1:0] tap_high;
    logic [1:0] ratio_low;
    logic [1:0] ratio_high;
  } lsft_state_s;

  lsft_state_s st;
  lsft_state_s next_st;
  logic [8:0] order_first;
  logic [8:0] order_next;
  logic order_last;
  logic [7:0] period;
  logic line_end;
  logic in_partial;
  logic eight_colour;
  logic [31:0] gamma_pick;
  logic [15:0] tap_pick;
  logic [4:0] porch_total;

  lsft_line_order u_order (
    .i_interleave(st.scan[lsft_pkg::BIT_INTERLEAVE]),
    .i_reverse(st.scan[lsft_pkg::BIT_REVERSE]),
    .i_line(st.line),
    .o_first(order_first),
    .o_next(order_next),
    .o_last(order_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Line period is clocks-per-line scaled by 1, 2, 4 or 8, so no oscillator change is needed
  assign period = 8'(st.clocks_per_line) << st.div;
  assign line_end = (st.clk_count == period - 8'h01) || (period == 8'h00);
  assign porch_total = 5'(st.front_porch_lines) + 5'(st.back_porch_lines);
  assign eight_colour = st.scan[lsft_pkg::BIT_EIGHT_COLOUR];
  // Partial window: start line in [8:0], end line in [24:16]
  assign in_partial = (st.line >= st.partial[8:0]) && (st.line <= st.partial[24:16]);

  always_comb
  begin
    next_st = st;
    next_st.line_start = 1'b0;
    next_st.frame_start = 1'b0;
    // Register writes
    if (i_write)
    begin
      case (i_address)
        lsft_pkg::ADDR_SCAN: next_st.scan = i_writedata[5:0];
        lsft_pkg::ADDR_TIMING:
        begin
          next_st.clocks_per_line = i_writedata[4:0];
          next_st.div = i_writedata[9:8];
          next_st.driven_line_count = i_writedata[24:16];
        end
        lsft_pkg::ADDR_PORCH:
        begin
          next_st.front_porch_lines = i_writedata[3:0];
          next_st.back_porch_lines = i_writedata[11:8];
        end
        lsft_pkg::ADDR_GAMMA_POS: next_st.gamma_pos = i_writedata;
        lsft_pkg::ADDR_GAMMA_NEG: next_st.gamma_neg = i_writedata;
        lsft_pkg::ADDR_PARTIAL: next_st.partial = i_writedata;
        lsft_pkg::ADDR_TAP: next_st.tap = i_writedata;
        default: ;
      endcase
    end
    // Reads take one wait state; unmapped reads return zero
    next_st.read_pending = i_read && !st.read_pending;
    case (i_address)
      lsft_pkg::ADDR_SCAN: next_st.readdata = {26'h0, st.scan};
      lsft_pkg::ADDR_TIMING: next_st.readdata = {7'h0, st.driven_line_count, 6'h0, st.div, 3'h0, st.clocks_per_line};
      lsft_pkg::ADDR_PORCH: next_st.readdata = {20'h0, st.back_porch_lines, 4'h0, st.front_porch_lines};
      lsft_pkg::ADDR_GAMMA_POS: next_st.readdata = st.gamma_pos;
      lsft_pkg::ADDR_GAMMA_NEG: next_st.readdata = st.gamma_neg;
      lsft_pkg::ADDR_PARTIAL: next_st.readdata = st.partial;
      lsft_pkg::ADDR_TAP: next_st.readdata = st.tap;
      lsft_pkg::ADDR_STATUS: next_st.readdata = {14'h0, st.state == lsft_pkg::LSFT_BLANK, st.polarity,
                                                  7'h0, st.line};
      default: next_st.readdata = 32'h0000_0000;
    endcase

    // Display source data: in eight-colour each component's MSB fills the rest
    if (eight_colour)
    begin
      next_st.source_dot = {{6{i_dot[17]}}, {6{i_dot[11]}}, {6{i_dot[5]}}};
    end
    else
    begin
      next_st.source_dot = i_dot;
    end

    case (st.state)
      lsft_pkg::LSFT_IDLE:
      begin
        if (st.scan[lsft_pkg::BIT_ENABLE])
        begin
          next_st.state = lsft_pkg::LSFT_DRAW;
          next_st.line = order_first;
          next_st.line_index = 9'h001;
          next_st.clk_count = 8'h00;
          next_st.line_start = 1'b1;
          next_st.frame_start = 1'b1;
        end
      end
      lsft_pkg::LSFT_DRAW:
      begin
        next_st.clk_count = line_end ? 8'h00 : st.clk_count + 8'h01;
        if (line_end)
        begin
          // Frame inversion is legal only in eight-colour; the host keeps to that
          if (!st.scan[lsft_pkg::BIT_FRAME_INV])
          begin
            next_st.polarity = !st.polarity;
          end
          if (order_last || st.line_index >= st.driven_line_count)
          begin
            next_st.state = lsft_pkg::LSFT_BLANK;
            next_st.blank_count = 5'h00;
          end
          else
          begin
            next_st.line = order_next;
            next_st.line_index = st.line_index + 9'h001;
            next_st.line_start = 1'b1;
          end
        end
      end
      lsft_pkg::LSFT_BLANK:
      begin
        next_st.clk_count = line_end ? 8'h00 : st.clk_count + 8'h01;
        if (line_end || porch_total == 5'h00)
        begin
          next_st.blank_count = st.blank_count + 5'h01;
          if (st.blank_count + 5'h01 >= porch_total)
          begin
            if (st.scan[lsft_pkg::BIT_FRAME_INV])
            begin
              next_st.polarity = !st.polarity;
            end
            next_st.clk_count = 8'h00;
            if (st.scan[lsft_pkg::BIT_ENABLE])
            begin
              next_st.state = lsft_pkg::LSFT_DRAW;
              next_st.line = order_first;
              next_st.line_index = 9'h001;
              next_st.line_start = 1'b1;
              next_st.frame_start = 1'b1;
            end
            else
            begin
              next_st.state = lsft_pkg::LSFT_IDLE;
            end
          end
        end
      end
      default: next_st.state = lsft_pkg::LSFT_IDLE;
    endcase

    // Gamma outputs are registered against the polarity of the coming cycle, so they never lag it
    gamma_pick = next_st.polarity ? next_st.gamma_neg : next_st.gamma_pos;
    // Tap word: positive half [15:0], negative half [31:16]; each half holds
    // tap_low[1:0], tap_high[3:2], ratio_low[5:4], ratio_high[7:6], fine5[10:8]
    tap_pick = next_st.polarity ? next_st.tap[31:16] : next_st.tap[15:0];
    next_st.level0_amp = gamma_pick[4:0];
    next_st.level31_amp = gamma_pick[9:5];
    next_st.grad_level4 = gamma_pick[12:10];
    next_st.grad_level27 = gamma_pick[15:13];
    next_st.fine_levels = {tap_pick[10:8], gamma_pick[30:16]};
    next_st.tap_low = tap_pick[1:0];
    next_st.tap_high = tap_pick[3:2];
    next_st.ratio_low = tap_pick[5:4];
    next_st.ratio_high = tap_pick[7:6];
    // Only the end-point amplitudes survive eight-colour; the mid supplies are off anyway
    if (next_st.scan[lsft_pkg::BIT_EIGHT_COLOUR])
    begin
      next_st.grad_level4 = 3'h0;
      next_st.grad_level27 = 3'h0;
      next_st.fine_levels = 18'h0_0000;
      next_st.tap_low = 2'h0;
      next_st.tap_high = 2'h0;
      next_st.ratio_low = 2'h0;
      next_st.ratio_high = 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st <= '0;
      st.scan <= lsft_pkg::RST_SCAN;
      st.clocks_per_line <= lsft_pkg::RST_CLOCKS_PER_LINE;
      st.div <= lsft_pkg::RST_DIV;
      st.driven_line_count <= lsft_pkg::RST_DRIVEN_LINES;
      st.front_porch_lines <= lsft_pkg::RST_FRONT_PORCH;
      st.back_porch_lines <= lsft_pkg::RST_BACK_PORCH;
      st.gamma_pos <= lsft_pkg::RST_GAMMA;
      st.gamma_neg <= lsft_pkg::RST_GAMMA;
      st.partial <= lsft_pkg::RST_PARTIAL;
      st.tap <= lsft_pkg::RST_GAMMA;
      st.state <= lsft_pkg::LSFT_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_waitrequest = i_read && !st.read_pending;
  assign o_readdata = st.readdata;
  assign o_gate_line = st.line;
  assign o_gate_active = (st.state == lsft_pkg::LSFT_DRAW);
  assign o_line_start = st.line_start;
  assign o_frame_start = st.frame_start;
  assign o_polarity = st.polarity;
  assign o_non_lit = (st.state == lsft_pkg::LSFT_DRAW) && st.scan[lsft_pkg::BIT_PARTIAL] && !in_partial;
  assign o_source_dot = st.source_dot;
  assign o_mid_levels_on = !eight_colour;
  // Gamma word: amp0[4:0], amp31[9:5], grad4[12:10], grad27[15:13], fine0..4[30:16]
  assign o_level0_amp = st.level0_amp;
  assign o_level31_amp = st.level31_amp;
  assign o_grad_level4 = st.grad_level4;
  assign o_grad_level27 = st.grad_level27;
  assign o_fine_levels = st.fine_levels;
  assign o_tap_low = st.tap_low;
  assign o_tap_high = st.tap_high;
  assign o_ratio_low = st.ratio_low;
  assign o_ratio_high = st.ratio_high;
endmodule : lsft_scan_timing

/* File: tb/lsft_scan_timing_chk.sv */
// Port checker for the panel scan and frame timing block.
// Assumes one clock domain and an async active-low reset.
module lsft_scan_timing_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic [17:0] i_dot,
  input wire logic [8:0] o_gate_line,
  input wire logic o_gate_active,
  input wire logic o_line_start,
  input wire logic o_frame_start,
  input wire logic o_non_lit,
  input wire logic [17:0] o_source_dot,
  input wire logic o_mid_levels_on,
  input wire logic [2:0] o_grad_level4,
  input wire logic [17:0] o_fine_levels,
  input wire logic [1:0] o_tap_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] dot_q;
  logic live_q;
  always_ff @(posedge i_clk) dot_q <= i_dot;
  // The dot register reads zero through reset, so dot checks wait one cycle past release
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  AST_FRAME_OPENS_LINE: assert property (o_frame_start |-> o_line_start && o_gate_active)
    else $error("frame start without line start");
  AST_LINE_PULSE: assert property (o_line_start |=> !o_line_start)
    else $error("line start held too long");
  AST_LINE_HOLDS: assert property (o_gate_active && !o_line_start |-> $stable(o_gate_line))
    else $error("gate line moved inside a line");
  AST_GATE_RANGE: assert property (o_gate_active |-> o_gate_line inside {[9'h001:9'h140]})
    else $error("gate line off the panel");
  // Mode is judged over two cycles since the dot register lags the mode by one
  AST_EIGHT_DOT: assert property (live_q && !o_mid_levels_on && !$past(o_mid_levels_on) |->
    o_source_dot == {{6{dot_q[17]}}, {6{dot_q[11]}}, {6{dot_q[5]}}}) else $error("dot not from MSB");
  AST_FULL_DOT: assert property (live_q && o_mid_levels_on && $past(o_mid_levels_on) |-> o_source_dot == dot_q)
    else $error("full colour dot altered");
  AST_EIGHT_GAMMA: assert property (!o_mid_levels_on |->
    o_grad_level4 == 3'h0 && o_fine_levels == 18'h0_0000 && o_tap_high == 2'h0) else $error("gamma not ignored");
  AST_NONLIT_DRAWN: assert property (o_non_lit |-> o_gate_active)
    else $error("non-lit outside drawing");
  AST_READ_WAIT: assert property ($rose(i_read) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("read wait wrong");
  AST_WRITE_NOWAIT: assert property (i_write |-> !o_waitrequest)
    else $error("write stalled");
endmodule : lsft_scan_timing_chk
bind lsft_scan_timing lsft_scan_timing_chk chk (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_read(i_read),
  .i_write(i_write),
  .o_waitrequest(o_waitrequest),
  .i_dot(i_dot),
  .o_gate_line(o_gate_line),
  .o_gate_active(o_gate_active),
  .o_line_start(o_line_start),
  .o_frame_start(o_frame_start),
  .o_non_lit(o_non_lit),
  .o_source_dot(o_source_dot),
  .o_mid_levels_on(o_mid_levels_on),
  .o_grad_level4(o_grad_level4),
  .o_fine_levels(o_fine_levels),
  .o_tap_high(o_tap_high)
);

/* File: tb/lsft_panel_model.sv */
// Panel side model: supplies the dot data carried to the source lines.
// Assumes the scan block samples the dot on every clock.
module lsft_panel_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_gate_active,
  output logic [17:0] o_dot
);
  timeunit 1ns;
  timeprecision 1ns;
  // Dots change every cycle so a stale copy cannot match
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_dot <= 18'h2_A5C3;
    else if (i_gate_active)
      o_dot <= {o_dot[16:0], o_dot[17] ^ o_dot[10]} ^ 18'h0_0104;
    else
      o_dot <= ~o_dot;
  end
endmodule : lsft_panel_model

/* File: tb/lcd_scan_frame_timing_bench.sv */
// Self-checking bench for the panel scan and frame timing block.
// Assumes the core/ files are compiled first.
module lcd_scan_frame_timing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_address = 4'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0000_0000;
  logic [31:0] o_readdata;
  logic [17:0] i_dot, o_source_dot, o_fine_levels;
  logic [8:0] o_gate_line;
  logic [4:0] o_level0_amp, o_level31_amp;
  logic [2:0] o_grad_level4, o_grad_level27;
  logic [1:0] o_tap_low, o_tap_high, o_ratio_low, o_ratio_high;
  logic o_waitrequest, o_gate_active, o_line_start, o_frame_start, o_polarity, o_non_lit, o_mid_levels_on;
  int bad_count = 0;
  int cmp_count = 0;
  lsft_scan_timing dut (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .i_dot(i_dot),
    .o_gate_line(o_gate_line),
    .o_gate_active(o_gate_active),
    .o_line_start(o_line_start),
    .o_frame_start(o_frame_start),
    .o_polarity(o_polarity),
    .o_non_lit(o_non_lit),
    .o_source_dot(o_source_dot),
    .o_mid_levels_on(o_mid_levels_on),
    .o_level0_amp(o_level0_amp),
    .o_level31_amp(o_level31_amp),
    .o_grad_level4(o_grad_level4),
    .o_grad_level27(o_grad_level27),
    .o_fine_levels(o_fine_levels),
    .o_tap_low(o_tap_low),
    .o_tap_high(o_tap_high),
    .o_ratio_low(o_ratio_low),
    .o_ratio_high(o_ratio_high)
  );
  lsft_panel_model panel (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_gate_active(o_gate_active), .o_dot(i_dot));
  always #10 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_read <= !w;
    i_write <= w;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_waitrequest !== 1'b0 && n < 50);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (n >= 50)
    begin
      check("waitrequest", 1'b0, 1'b1);
      close_out();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check("readdata", e, q);
  endtask : rd
  // Frame set waits for a line that also opens a frame
  task automatic next_line(input bit frame);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while ((o_line_start !== 1'b1 || (frame && o_frame_start !== 1'b1)) && n < 20000);
    if (n >= 20000)
    begin
      check("line start", 1'b1, 1'b0);
      close_out();
    end
  endtask : next_line
  function automatic logic [8:0] exp_line(input int m, input int k);
    int h;
    h = (k < 160) ? 2 * k : 2 * (k - 160);
    case (m)
      0: return 9'(k + 1);
      1: return 9'((k < 160) ? h + 1 : h + 2);
      2: return 9'(320 - k);
      default: return 9'((k < 160) ? 320 - h : 319 - h);
    endcase
  endfunction : exp_line
  // Gamma fields expected for the words written in t_rate, by polarity
  task automatic gamma_is(input logic neg);
    check("level0", neg ? 5'h0B : 5'h15, o_level0_amp);
    check("level31", 5'h0A, o_level31_amp);
    check("grad27", 3'h7, o_grad_level27);
    check("fine", neg ? 18'h2_FFFF : 18'h1_7FFF, o_fine_levels);
    check("tap low", neg ? 2'h1 : 2'h2, o_tap_low);
    check("tap high", neg ? 2'h2 : 2'h1, o_tap_high);
    check("ratio", neg ? 4'h3 : 4'hC, {o_ratio_high, o_ratio_low});
  endtask : gamma_is
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(4'h1, 32'h0140_0010);
    rd(4'h2, 32'h0000_0E02);
    wr(4'h7, 32'hFFFF_FFFF);
    rd(4'h7, 32'hFFFF_FFFF);
    $display("test regs done");
  endtask : t_regs
  task automatic t_order;
    logic p;
    wr(4'h1, 32'h0140_0002);
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h0, 32'h0000_0020 | m);
      next_line(1'b1);
      for (int k = 0; k < 320; k++)
      begin
        if (k > 0)
          next_line(1'b0);
        check("gate line", exp_line(m, k), o_gate_line);
        if (k > 0)
          check("line polarity", !p, o_polarity);
        p = o_polarity;
      end
      next_line(1'b0);
      check("restart", 1'b1, o_frame_start);
      wr(4'h0, 32'h0000_0000);
    end
    $display("test order done");
  endtask : t_order
  task automatic t_rate;
    logic p;
    int n;
    wr(4'h1, 32'h0004_0103);
    wr(4'h2, 32'h0000_0102);
    wr(4'h3, 32'h7FFF_FD55);
    wr(4'h4, 32'h7FFF_FD4B);
    wr(4'h7, 32'h0539_02C6);
    wr(4'h0, 32'h0000_002C);
    next_line(1'b1);
    p = o_polarity;
    check("mid levels", 1'b0, o_mid_levels_on);
    check("level0", p ? 5'h0B : 5'h15, o_level0_amp);
    check("fine", 18'h0_0000, o_fine_levels);
    check("tap eight", 6'h00, {o_tap_low, o_ratio_low, o_ratio_high});
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
      if (o_line_start === 1'b1 && o_frame_start !== 1'b1)
        check("frame polarity", p, o_polarity);
    end
    while (o_frame_start !== 1'b1 && n < 1000);
    check("frame cycles", 42, n);
    check("flip", !p, o_polarity);
    wr(4'h0, 32'h0000_0020);
    repeat (2) @(posedge i_clk);
    check("grad4", 3'h7, o_grad_level4);
    check("mid levels", 1'b1, o_mid_levels_on);
    next_line(1'b0);
    p = o_polarity;
    gamma_is(p);
    next_line(1'b0);
    check("line flip", !p, o_polarity);
    gamma_is(!p);
    $display("test rate done");
  endtask : t_rate
  task automatic t_partial;
    wr(4'h1, 32'h0008_0002);
    wr(4'h5, 32'h0005_0003);
    wr(4'h0, 32'h0000_0030);
    next_line(1'b1);
    for (int k = 1; k <= 8; k++)
    begin
      if (k > 1)
        next_line(1'b0);
      @(posedge i_clk);
      check("non-lit", k < 3 || k > 5, o_non_lit);
    end
    $display("test partial done");
  endtask : t_partial
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_order();
    t_rate();
    t_partial();
    close_out();
  end
endmodule : lcd_scan_frame_timing_bench
